// File: psc_strap_clk.sv
// strap sampling, ratio decode and derived clock generation for the platform
`timescale 1ns/1ps
module psc_strap_clk
  import psc_pkg::*;
#(
  parameter int NSERDES = SERDES_N,
  parameter int NLB = LB_OUTS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [PLAT_W-1:0] platform_ratio_strap,
  input wire logic [CORE_W-1:0] core_ratio_strap,
  input wire logic core_speed_strap,
  input wire logic network_divider_strap,
  input wire logic [LB_W-1:0] local_bus_divider_field,
  output psc_cfg_t cfg_q,
  output logic cfg_done_q,
  output logic platform_pll_en_q,
  output logic core_pll_en_q,
  output logic pci_pll_en_q,
  output logic [NSERDES-1:0] serdes_pll_en_q,
  output logic mem_bus_clk_q,
  output logic [NLB-1:0] local_bus_clock_out
);
  localparam int SW = PLAT_W + CORE_W + 2;

  logic [SW-1:0] strap_s1_q;
  logic [SW-1:0] strap_s2_q;
  psc_state_t state_q;
  psc_state_t state_d;
  logic [1:0] settle_q;
  logic lb_clk;

  // two-stage synchroniser for the strap pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end else begin
      strap_s1_q <= {platform_ratio_strap, core_ratio_strap, core_speed_strap,
                     network_divider_strap};
      strap_s2_q <= strap_s1_q;
    end
  end

  // decode of the synchronised straps
  wire logic [PLAT_W-1:0] plat_code = strap_s2_q[SW-1 -: PLAT_W];
  wire logic [CORE_W-1:0] core_code = strap_s2_q[CORE_W+1 -: CORE_W];
  wire logic plat_ok = psc_plat_legal(plat_code);
  wire logic [3:0] core_x2 = psc_core_x2(core_code);
  wire logic core_ok = (core_x2 != CORE_NONE);
  psc_cfg_t cfg_dec;
  assign cfg_dec.plat_ratio = plat_ok ? plat_code : PLAT_NONE;
  assign cfg_dec.plat_ok = plat_ok;
  assign cfg_dec.core_x2 = core_x2;
  assign cfg_dec.core_ok = core_ok;
  assign cfg_dec.core_speed_hi = strap_s2_q[1];
  assign cfg_dec.net_div_hi = strap_s2_q[0];

  // settle, latch once, then run until the next reset
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PSC_SETTLE: if (settle_q == SETTLE_CYC) state_d = PSC_LATCH;
      PSC_LATCH: state_d = PSC_RUN;
      PSC_RUN: state_d = PSC_RUN;
      default: state_d = PSC_SETTLE;
    endcase
  end

  // state and one-time capture of the configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PSC_SETTLE;
      settle_q <= '0;
      cfg_q <= '0;
      cfg_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == PSC_SETTLE) settle_q <= settle_q + 2'h1;
      if (state_q == PSC_LATCH) begin
        cfg_q <= cfg_dec;
        cfg_done_q <= 1'b1;
      end
    end
  end

  // platform and core PLL enables follow the latched configuration; PCI and SerDes enables follow the latch alone
  wire logic plat_run_d = cfg_done_q && cfg_q.plat_ok;
  wire logic core_run_d = plat_run_d && platform_pll_en_q && cfg_q.core_ok;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      platform_pll_en_q <= 1'b0;
      core_pll_en_q <= 1'b0;
      pci_pll_en_q <= 1'b0;
      serdes_pll_en_q <= '0;
    end else begin
      platform_pll_en_q <= plat_run_d;
      core_pll_en_q <= core_run_d;
      pci_pll_en_q <= cfg_done_q;
      serdes_pll_en_q <= {NSERDES{cfg_done_q}};
    end
  end

  // memory bus clock toggles every platform cycle: half rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mem_bus_clk_q <= 1'b0;
    else mem_bus_clk_q <= platform_pll_en_q ? ~mem_bus_clk_q : 1'b0;
  end

  // local bus clock divider, fanned out to each output pin
  psc_clk_div #(.W(LB_W)) u_lb_div (
    .clk(clk),
    .nrst(nrst),
    .en(platform_pll_en_q),
    .div(local_bus_divider_field),
    .clk_q(lb_clk)
  );
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) local_bus_clock_out <= '0;
    else local_bus_clock_out <= {NLB{lb_clk}};
  end

  // checks
  property p_plat_latch;
    @(posedge clk) disable iff (!nrst)
    (state_q == PSC_LATCH) |=> (cfg_q.plat_ratio == ($past(plat_ok) ? $past(plat_code) : PLAT_NONE));
  endproperty
  a_plat_latch: assert property (p_plat_latch) else $error("platform ratio latch wrong");

  property p_plat_reserved;
    @(posedge clk) disable iff (!nrst)
    cfg_done_q && !cfg_q.plat_ok |-> (cfg_q.plat_ratio == PLAT_NONE) && !platform_pll_en_q;
  endproperty
  a_plat_reserved: assert property (p_plat_reserved) else $error("reserved code ran pll");

  property p_core_latch;
    @(posedge clk) disable iff (!nrst)
    (state_q == PSC_LATCH) |=> (cfg_q.core_x2 == psc_core_x2($past(core_code)));
  endproperty
  a_core_latch: assert property (p_core_latch) else $error("core ratio latch wrong");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
    (state_q == PSC_RUN) |=> $stable(cfg_q) && cfg_done_q;
  endproperty
  a_hold: assert property (p_hold) else $error("latched config changed");

  property p_plat_en;
    @(posedge clk) disable iff (!nrst)
    $rose(cfg_done_q) && cfg_q.plat_ok |=> platform_pll_en_q ##1 (core_pll_en_q == cfg_q.core_ok);
  endproperty
  a_plat_en: assert property (p_plat_en) else $error("pll enable sequence wrong");

  property p_core_en;
    @(posedge clk) disable iff (!nrst)
    core_pll_en_q |-> platform_pll_en_q && cfg_q.core_ok;
  endproperty
  a_core_en: assert property (p_core_en) else $error("core pll without platform");

  property p_mem_half;
    @(posedge clk) disable iff (!nrst)
    platform_pll_en_q ##1 platform_pll_en_q |-> (mem_bus_clk_q != $past(mem_bus_clk_q));
  endproperty
  a_mem_half: assert property (p_mem_half) else $error("memory clock not half rate");

  property p_lb_div2;
    @(posedge clk) disable iff (!nrst)
    (platform_pll_en_q && local_bus_divider_field == LB_DIV_MIN)[*4] |->
      (local_bus_clock_out[0] != $past(local_bus_clock_out[0]));
  endproperty
  a_lb_div2: assert property (p_lb_div2) else $error("local bus divide by two wrong");

  property p_side_plls;
    @(posedge clk) disable iff (!nrst)
    $rose(cfg_done_q) |=> pci_pll_en_q && (serdes_pll_en_q == {NSERDES{1'b1}});
  endproperty
  a_side_plls: assert property (p_side_plls) else $error("pci or serdes pll not enabled");
endmodule : psc_strap_clk

// File: psc_pkg.sv
// shared constants, types and strap decoders for the strap clocking block
package psc_pkg;
  localparam int PLAT_W = 5;
  localparam int CORE_W = 4;
  localparam int LB_W = 8;
  localparam int LB_OUTS = 3;
  localparam int SERDES_N = 2;

  // platform ratio strap codes; a legal code equals the ratio itself
  localparam logic [4:0] PLAT_LO = 5'h02;
  localparam logic [4:0] PLAT_HI = 5'h0A;
  localparam logic [4:0] PLAT_C12 = 5'h0C;
  localparam logic [4:0] PLAT_C14 = 5'h0E;
  localparam logic [4:0] PLAT_C15 = 5'h0F;
  localparam logic [4:0] PLAT_C16 = 5'h10;
  localparam logic [4:0] PLAT_C17 = 5'h11;
  localparam logic [4:0] PLAT_C18 = 5'h12;
  localparam logic [4:0] PLAT_NONE = 5'h00;

  // core ratio strap codes and ratio times two
  localparam logic [3:0] CORE_C20 = 4'h8;
  localparam logic [3:0] CORE_C25 = 4'hA;
  localparam logic [3:0] CORE_C30 = 4'hC;
  localparam logic [3:0] CORE_C35 = 4'hE;
  localparam logic [3:0] CORE_C40 = 4'h0;
  localparam logic [3:0] CORE_C45 = 4'h2;
  localparam logic [3:0] CORE_X2_20 = 4'h4;
  localparam logic [3:0] CORE_X2_25 = 4'h5;
  localparam logic [3:0] CORE_X2_30 = 4'h6;
  localparam logic [3:0] CORE_X2_35 = 4'h7;
  localparam logic [3:0] CORE_X2_40 = 4'h8;
  localparam logic [3:0] CORE_X2_45 = 4'h9;
  localparam logic [3:0] CORE_NONE = 4'h0;

  // edges after reset release before synced straps are trusted
  localparam logic [1:0] SETTLE_CYC = 2'h2;
  localparam logic [7:0] LB_DIV_MIN = 8'h02;

  typedef struct packed {
    logic [4:0] plat_ratio;
    logic plat_ok;
    logic [3:0] core_x2;
    logic core_ok;
    logic core_speed_hi;
    logic net_div_hi;
  } psc_cfg_t;

  typedef enum logic [1:0] {PSC_SETTLE, PSC_LATCH, PSC_RUN} psc_state_t;

  function automatic logic psc_plat_legal(input logic [4:0] code);
    psc_plat_legal = ((code >= PLAT_LO) && (code <= PLAT_HI)) || (code == PLAT_C12) ||
                     (code == PLAT_C14) || (code == PLAT_C15) || (code == PLAT_C16) ||
                     (code == PLAT_C17) || (code == PLAT_C18);
  endfunction : psc_plat_legal

  function automatic logic [3:0] psc_core_x2(input logic [3:0] code);
    logic [3:0] r;
    r = CORE_NONE;
    case (code)
      CORE_C20: r = CORE_X2_20;
      CORE_C25: r = CORE_X2_25;
      CORE_C30: r = CORE_X2_30;
      CORE_C35: r = CORE_X2_35;
      CORE_C40: r = CORE_X2_40;
      CORE_C45: r = CORE_X2_45;
      default: r = CORE_NONE;
    endcase
    psc_core_x2 = r;
  endfunction : psc_core_x2
endpackage : psc_pkg

// File: psc_clk_div.sv
// programmable clock divider producing a registered divided clock level
`timescale 1ns/1ps
module psc_clk_div
  import psc_pkg::*;
#(
  parameter int W = LB_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [W-1:0] div,
  output logic clk_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic [W-1:0] eff = (div < W'(LB_DIV_MIN)) ? W'(LB_DIV_MIN) : div; // floor of two
  wire logic [W-1:0] half = eff >> 1;
  wire logic wrap = (cnt_q >= eff - W'(1));

  // count one period of the divided clock
  assign cnt_d = (!en || wrap) ? '0 : cnt_q + W'(1);

  // high for the first eff/2 cycles of each period, rounded down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= en && (cnt_d < half);
    end
  end
endmodule : psc_clk_div

// File: psc_board.sv
// board model: drives ratio and speed straps for one chosen configuration
`timescale 1ns/1ps
module psc_board
  import psc_pkg::*;
#(
  parameter int REF_MHZ = 50
) (
  input wire logic [PLAT_W-1:0] plat_sel,
  input wire logic [CORE_W-1:0] core_sel,
  input wire logic scramble,
  output logic [PLAT_W-1:0] platform_ratio_strap,
  output logic [CORE_W-1:0] core_ratio_strap,
  output logic core_speed_strap,
  output logic network_divider_strap
);
  logic [3:0] x2;
  int plat_mhz;
  // core ratio times two, for the speed strap choice
  always_comb begin
    case (core_sel)
      4'h8: x2 = 4'h4;
      4'hA: x2 = 4'h5;
      4'hC: x2 = 4'h6;
      4'hE: x2 = 4'h7;
      4'h0: x2 = 4'h8;
      4'h2: x2 = 4'h9;
      default: x2 = 4'h0;
    endcase
  end
  // scramble flips every pin after the latch to show it is ignored
  assign plat_mhz = REF_MHZ * int'(plat_sel);
  assign platform_ratio_strap = plat_sel ^ {PLAT_W{scramble}};
  assign core_ratio_strap = core_sel ^ {CORE_W{scramble}};
  assign network_divider_strap = (plat_mhz > 400) ^ scramble;
  assign core_speed_strap = ((plat_mhz * int'(x2)) > 1600) ^ scramble;
endmodule : psc_board

// File: psc_strap_clk_bench.sv
// bench for strap latch, ratio decode and derived clocks
`timescale 1ns/1ps
module psc_strap_clk_bench
  import psc_pkg::*;
;
  typedef struct packed {logic [4:0] pc; logic [3:0] cc; logic [4:0] er; logic [3:0] ex;} psc_row_t;
  localparam psc_row_t ROWS [10] = '{'{5'h02, 4'h8, 5'h02, 4'h4}, '{5'h0A, 4'hA, 5'h0A, 4'h5},
    '{5'h0C, 4'hC, 5'h0C, 4'h6}, '{5'h0E, 4'hE, 5'h0E, 4'h7}, '{5'h0F, 4'h0, 5'h0F, 4'h8},
    '{5'h10, 4'h2, 5'h10, 4'h9}, '{5'h11, 4'h1, 5'h11, 4'h0}, '{5'h12, 4'hF, 5'h12, 4'h0},
    '{5'h01, 4'h8, 5'h00, 4'h4}, '{5'h0B, 4'h0, 5'h00, 4'h8}};
  logic clk, nrst, scramble, spd, net;
  logic [4:0] plat_sel, ps;
  logic [3:0] core_sel, cs;
  logic [7:0] div;
  psc_cfg_t cfg_q, e;
  logic cfg_done_q, platform_pll_en_q, core_pll_en_q, pci_pll_en_q, mem_bus_clk_q;
  logic [1:0] serdes_pll_en_q;
  logic [2:0] local_bus_clock_out;
  int n_fail, check_count;
  psc_board psc_board_inst (.plat_sel(plat_sel), .core_sel(core_sel), .scramble(scramble),
    .platform_ratio_strap(ps), .core_ratio_strap(cs), .core_speed_strap(spd),
    .network_divider_strap(net));
  psc_strap_clk psc_strap_clk_inst (.clk(clk), .nrst(nrst), .platform_ratio_strap(ps),
    .core_ratio_strap(cs), .core_speed_strap(spd), .network_divider_strap(net),
    .local_bus_divider_field(div), .cfg_q(cfg_q), .cfg_done_q(cfg_done_q),
    .platform_pll_en_q(platform_pll_en_q), .core_pll_en_q(core_pll_en_q),
    .pci_pll_en_q(pci_pll_en_q), .serdes_pll_en_q(serdes_pll_en_q),
    .mem_bus_clk_q(mem_bus_clk_q), .local_bus_clock_out(local_bus_clock_out));
  // compare one value with its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // print counts and verdict, then stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // reset with given straps, latch, then check enables and derived clocks
  task automatic run_row(input psc_row_t r, input logic [7:0] dv);
    int k, m, h, x, n;
    @(posedge clk);
    nrst <= 1'b0;
    scramble <= 1'b0;
    plat_sel <= r.pc;
    core_sel <= r.cc;
    div <= dv;
    repeat (20) @(posedge clk);
    #1 chk({cfg_q, cfg_done_q, platform_pll_en_q, core_pll_en_q, pci_pll_en_q, serdes_pll_en_q,
      mem_bus_clk_q, local_bus_clock_out}, 0);
    e = '{r.er, r.er != 5'h00, r.ex, r.ex != 4'h0, spd, net};
    @(posedge clk);
    nrst <= 1'b1;
    k = 0;
    while (cfg_done_q !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    // settle count edges, the edge that leaves settle, plus the latch edge
    chk(k, int'(SETTLE_CYC) + 2);
    if (k >= 20) end_sim();
    chk(cfg_q, e);
    repeat (2) @(posedge clk);
    #1 chk(platform_pll_en_q, e.plat_ok);
    chk(core_pll_en_q, e.plat_ok & e.core_ok);
    chk({pci_pll_en_q, serdes_pll_en_q}, 3'b111);
    @(posedge clk);
    scramble <= 1'b1;
    n = (dv < 8'h02) ? 2 : int'(dv);
    repeat (2 * n + 4) @(posedge clk);
    m = 0;
    h = 0;
    x = 0;
    repeat (4 * n) begin
      @(posedge clk);
      #1 m += int'(mem_bus_clk_q === 1'b1);
      h += int'(local_bus_clock_out === 3'b111);
      x += int'(local_bus_clock_out !== 3'b111 && local_bus_clock_out !== 3'b000);
    end
    chk(m, e.plat_ok ? 2 * n : 0);
    chk(h, e.plat_ok ? 4 * (n / 2) : 0);
    chk(x, 0);
    chk(cfg_q, e);
  endtask : run_row
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  // main sequence: one reset and latch per table row
  initial begin
    nrst = 1'b0;
    scramble = 1'b0;
    plat_sel = 5'h02;
    core_sel = 4'h8;
    div = 8'h00;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      run_row(ROWS[i], 8'(i));
    end
    // widest divider on a legal row, then reset pulled in mid-run
    run_row(ROWS[5], 8'hFF);
    @(posedge clk);
    nrst <= 1'b0;
    #1 chk({cfg_q, cfg_done_q, platform_pll_en_q, core_pll_en_q, pci_pll_en_q, serdes_pll_en_q,
      mem_bus_clk_q, local_bus_clock_out}, 0);
    end_sim();
  end
endmodule : psc_strap_clk_bench
